// ### hdl/omr_cfg.svh
`ifndef OMR_CFG_SVH
`define OMR_CFG_SVH
// ----------------------------------------
// field positions
// ----------------------------------------
`define OMR_WIDTH        24
`define OMR_SEN_BIT      20
`define OMR_WRP_BIT      19
`define OMR_EOV_BIT      18
`define OMR_EUN_BIT      17
`define OMR_XYS_BIT      16
`define OMR_ATE_BIT      15
`define OMR_APD_BIT      14
`define OMR_ABE_BIT      13
`define OMR_BRT_BIT      12
`define OMR_TAS_BIT      11
`define OMR_BE_BIT       10
`define OMR_CDP_HI       9
`define OMR_CDP_LO       8
`define OMR_MS_BIT       7
`define OMR_SD_BIT       6
`define OMR_EBD_BIT      4
// ----------------------------------------
// masks and reset values
// ----------------------------------------
`define OMR_WR_MASK      24'h1fffdf
`define OMR_LOW_MASK     24'h00ffff
`define OMR_STACK_MASK   24'h1f0000
`define OMR_RESET_VAL    24'h000300
// ----------------------------------------
// timing
// ----------------------------------------
`define OMR_STOP_LONG_CYC  131072
`define OMR_STOP_SHORT_CYC 16
`define OMR_CACHE_BURST    4
`endif

// ### hdl/omr_core.sv
`timescale 1ns/1ns
`include "omr_cfg.svh"
module omr_core (
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic [3:0]         mode_pins,
    input  wire omr_pkg::omr_wr_t   wr,
    input  wire omr_pkg::omr_stack_t stk,
    input  wire logic [3:0]         attr_req,
    input  wire logic [1:0]         core_priority_field,
    input  wire logic [1:0]         dma_priority,
    input  wire logic               bus_grant_in,
    input  wire logic               bus_busy_in,
    input  wire logic               transfer_ack_in,
    input  wire logic               stop_exit,
    output logic [23:0]             operating_mode_control,
    output logic [3:0]              address_attribute_out,
    output logic                    stack_error,
    output logic                    core_wins,
    output logic [2:0]              burst_len,
    output logic                    uf_counts,
    output logic                    bus_release_extra,
    output logic                    bus_enable,
    output logic                    grant_accepted,
    output logic                    busy_accepted,
    output logic                    ack_accepted,
    output logic                    stop_done
);
    // ----------------------------------------
    // write opcodes
    // ----------------------------------------
    localparam logic [1:0] OP_MOVE = 2'h0;
    localparam logic [1:0] OP_AND  = 2'h1;
    localparam logic [1:0] OP_OR   = 2'h2;
    localparam logic [17:0] STOP_LONG  = 18'(`OMR_STOP_LONG_CYC);
    localparam logic [17:0] STOP_SHORT = 18'(`OMR_STOP_SHORT_CYC);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic grant_s;
    logic busy_s;
    logic ack_s;
    logic grant_raw_r;
    logic busy_raw_r;
    logic ack_raw_r;
    logic [3:0] mode_meta_r;
    logic [3:0] mode_sync_r;

    omr_sync2 u_sync_grant (.clock(clock), .resetn(resetn), .d(bus_grant_in), .q(grant_s));
    omr_sync2 u_sync_busy  (.clock(clock), .resetn(resetn), .d(bus_busy_in),  .q(busy_s));
    omr_sync2 u_sync_ack   (.clock(clock), .resetn(resetn), .d(transfer_ack_in), .q(ack_s));

    // direct path still registered once; partner keeps these synchronous
    always_ff @(posedge clock) begin
        grant_raw_r <= bus_grant_in;
        busy_raw_r  <= bus_busy_in;
        ack_raw_r   <= transfer_ack_in;
    end

    // mode pins are static in reset but still come from outside the clock domain
    always_ff @(posedge clock) begin
        mode_meta_r <= mode_pins;
        mode_sync_r <= mode_meta_r;
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    omr_pkg::omr_state_t st_r;
    omr_pkg::omr_state_t st_nxt;
    logic [23:0]         w;
    logic [23:0]         m;
    logic                ov_ev;
    logic                un_ev;
    omr_pkg::omr_cdp_t   core_dma_priority;

    always_comb begin
        st_nxt = st_r;
        m      = st_r.omr;
        w      = st_r.omr;
        ov_ev  = 1'b0;
        un_ev  = 1'b0;
        core_dma_priority    = omr_pkg::omr_cdp_t'(st_r.omr[`OMR_CDP_HI:`OMR_CDP_LO]);
        // instruction writes
        if (wr.wr_en) begin
            unique case (wr.op)
                OP_MOVE: w = wr.data;
                OP_AND:  w = st_r.omr & (wr.data | `OMR_STACK_MASK);
                OP_OR:   w = st_r.omr | (wr.data & `OMR_LOW_MASK);
                default: w = st_r.omr;
            endcase
            m = w & `OMR_WR_MASK;
        end
        // implicit stack updates
        if (m[`OMR_SEN_BIT] || st_r.omr[`OMR_SEN_BIT]) begin
            ov_ev = st_r.omr[`OMR_SEN_BIT] && stk.push_req
                    && (stk.stack_pointer == stk.stack_size);
            un_ev = st_r.omr[`OMR_SEN_BIT] && stk.pull_req
                    && (stk.stack_pointer == 5'h00);
        end
        if (st_r.omr[`OMR_SEN_BIT] && stk.wrap_start) begin
            m[`OMR_WRP_BIT] = 1'b1;
        end
        if (ov_ev) begin
            m[`OMR_EOV_BIT] = 1'b1;
        end
        if (un_ev) begin
            m[`OMR_EUN_BIT] = 1'b1;
        end
        st_nxt.omr = m;
        // stack error on a rising flag
        st_nxt.stack_err = (m[`OMR_EOV_BIT] & ~st_r.omr[`OMR_EOV_BIT])
                         | (m[`OMR_EUN_BIT] & ~st_r.omr[`OMR_EUN_BIT]);
        st_nxt.uf_counts = st_r.omr[`OMR_SEN_BIT];
        // attribute priority
        if (st_r.omr[`OMR_APD_BIT]) begin
            st_nxt.attr_out = attr_req;
        end else if (attr_req[3]) begin
            st_nxt.attr_out = 4'h8;
        end else if (attr_req[2]) begin
            st_nxt.attr_out = 4'h4;
        end else if (attr_req[1]) begin
            st_nxt.attr_out = 4'h2;
        end else begin
            st_nxt.attr_out = {3'h0, attr_req[0]};
        end
        // core versus dma
        unique case (core_dma_priority)
            omr_pkg::OMR_CDP_COMPARE:   st_nxt.core_wins =
                (core_priority_field >= dma_priority);
            omr_pkg::OMR_CDP_DMA_HIGH:  st_nxt.core_wins = 1'b0;
            omr_pkg::OMR_CDP_EQUAL:     st_nxt.core_wins = 1'b1;
            omr_pkg::OMR_CDP_CORE_HIGH: st_nxt.core_wins = 1'b1;
        endcase
        st_nxt.burst_len = st_r.omr[`OMR_BE_BIT] ? 3'(`OMR_CACHE_BURST) : 3'h1;
        st_nxt.bus_release_extra = st_r.omr[`OMR_BRT_BIT];
        st_nxt.bus_enable = ~st_r.omr[`OMR_EBD_BIT];
        st_nxt.grant_q = st_r.omr[`OMR_ABE_BIT] ? grant_s : grant_raw_r;
        st_nxt.busy_q  = st_r.omr[`OMR_ABE_BIT] ? busy_s  : busy_raw_r;
        st_nxt.ack_q   = st_r.omr[`OMR_TAS_BIT] ? ack_s   : ack_raw_r;
        // stop exit delay
        st_nxt.stop_done = 1'b0;
        if (stop_exit) begin
            st_nxt.stop_cnt = st_r.omr[`OMR_SD_BIT] ? STOP_SHORT : STOP_LONG;
        end else if (st_r.stop_cnt != 18'h0) begin
            st_nxt.stop_cnt = st_r.stop_cnt - 18'h1;
            st_nxt.stop_done = (st_r.stop_cnt == 18'h1);
        end
        st_nxt.rst_seen = 1'b1;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_r          <= '0;
            st_r.omr      <= `OMR_RESET_VAL;
            st_r.bus_enable <= 1'b1;
            st_r.core_wins  <= 1'b1;
            st_r.burst_len  <= 3'h1;
            st_r.omr[3:0] <= mode_sync_r;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // space select, trace and memory switch reach their users through this value
    assign operating_mode_control = st_r.omr;
    assign address_attribute_out  = st_r.attr_out;
    assign stack_error            = st_r.stack_err;
    assign core_wins              = st_r.core_wins;
    assign burst_len              = st_r.burst_len;
    assign uf_counts              = st_r.uf_counts;
    assign bus_release_extra      = st_r.bus_release_extra;
    assign bus_enable             = st_r.bus_enable;
    assign grant_accepted         = st_r.grant_q;
    assign busy_accepted          = st_r.busy_q;
    assign ack_accepted           = st_r.ack_q;
    assign stop_done              = st_r.stop_done;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_reserved;
        @(posedge clock) disable iff (!resetn) st_r.omr[23:21] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_ovf_err;
        @(posedge clock) disable iff (!resetn)
        ($rose(st_r.omr[`OMR_EOV_BIT])) |-> st_r.stack_err;
    endproperty
    a_ovf_err: assert property (p_ovf_err) else $error("no stack error on overflow");

    property p_ovf_set;
        @(posedge clock) disable iff (!resetn)
        (st_r.omr[`OMR_SEN_BIT] && stk.push_req && stk.stack_pointer == stk.stack_size)
        |=> st_r.omr[`OMR_EOV_BIT];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    property p_un_set;
        @(posedge clock) disable iff (!resetn)
        (st_r.omr[`OMR_SEN_BIT] && stk.pull_req && stk.stack_pointer == 5'h00)
        |=> st_r.omr[`OMR_EUN_BIT];
    endproperty
    a_un_set: assert property (p_un_set) else $error("underflow flag not set");

    property p_wrp_sticky;
        @(posedge clock) disable iff (!resetn)
        (st_r.omr[`OMR_WRP_BIT] && !(wr.wr_en && wr.op == OP_MOVE)) |=> st_r.omr[`OMR_WRP_BIT];
    endproperty
    a_wrp_sticky: assert property (p_wrp_sticky) else $error("wrap flag lost");

    property p_attr_one;
        @(posedge clock) disable iff (!resetn)
        !st_r.omr[`OMR_APD_BIT] |=> $onehot0(st_r.attr_out);
    endproperty
    a_attr_one: assert property (p_attr_one) else $error("attributes not exclusive");

    property p_burst;
        @(posedge clock) disable iff (!resetn)
        st_r.omr[`OMR_BE_BIT] |=> st_r.burst_len == 3'h4;
    endproperty
    a_burst: assert property (p_burst) else $error("burst length wrong");

    property p_cdp_dma;
        @(posedge clock) disable iff (!resetn)
        (st_r.omr[9:8] == 2'h1) |=> !st_r.core_wins;
    endproperty
    a_cdp_dma: assert property (p_cdp_dma) else $error("dma precedence wrong");

    // cycles since the last stop exit, saturating; checks the short delay end point
    logic [4:0] stop_age_r;
    logic       stop_short_r;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            stop_age_r   <= 5'h1f;
            stop_short_r <= 1'b0;
        end else if (stop_exit) begin
            stop_age_r   <= 5'h00;
            stop_short_r <= st_r.omr[`OMR_SD_BIT];
        end else if (stop_age_r != 5'h1f) begin
            stop_age_r   <= stop_age_r + 5'h01;
        end
    end

    property p_stop_short;
        @(posedge clock) disable iff (!resetn)
        stop_short_r |-> (st_r.stop_done == (stop_age_r == 5'(`OMR_STOP_SHORT_CYC)));
    endproperty
    a_stop_short: assert property (p_stop_short) else $error("short stop delay wrong");

    property p_ebd;
        @(posedge clock) disable iff (!resetn)
        st_r.omr[`OMR_EBD_BIT] |=> !st_r.bus_enable;
    endproperty
    a_ebd: assert property (p_ebd) else $error("bus not disabled");

    property p_un_err;
        @(posedge clock) disable iff (!resetn)
        $rose(st_r.omr[`OMR_EUN_BIT]) |-> st_r.stack_err;
    endproperty
    a_un_err: assert property (p_un_err) else $error("no stack error on underflow");

    property p_err_cause;
        @(posedge clock) disable iff (!resetn)
        st_r.stack_err |-> ($rose(st_r.omr[`OMR_EOV_BIT]) || $rose(st_r.omr[`OMR_EUN_BIT]));
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("stack error without flag rise");

    property p_high_kept;
        @(posedge clock) disable iff (!resetn)
        (wr.wr_en && wr.op != OP_MOVE && !stk.push_req && !stk.pull_req && !stk.wrap_start)
        |=> st_r.omr[23:16] == $past(st_r.omr[23:16]);
    endproperty
    a_high_kept: assert property (p_high_kept) else $error("logic write changed stack byte");

    property p_cdp_core;
        @(posedge clock) disable iff (!resetn)
        (st_r.omr[`OMR_CDP_HI:`OMR_CDP_LO] == 2'h3) |=> st_r.core_wins;
    endproperty
    a_cdp_core: assert property (p_cdp_core) else $error("core precedence wrong");

    property p_uf;
        @(posedge clock) disable iff (!resetn)
        1'b1 |=> (st_r.uf_counts == $past(st_r.omr[`OMR_SEN_BIT]));
    endproperty
    a_uf: assert property (p_uf) else $error("pointer underflow mode wrong");
endmodule

// ### hdl/omr_pkg.sv
package omr_pkg;
    typedef enum logic [1:0] {
        OMR_CDP_COMPARE,
        OMR_CDP_DMA_HIGH,
        OMR_CDP_EQUAL,
        OMR_CDP_CORE_HIGH
    } omr_cdp_t;

    typedef struct packed {
        logic       wr_en;
        logic [1:0] op;
        logic [23:0] data;
    } omr_wr_t;

    typedef struct packed {
        logic push_req;
        logic pull_req;
        logic wrap_start;
        logic [4:0] stack_pointer;
        logic [4:0] stack_size;
    } omr_stack_t;

    typedef struct packed {
        logic [23:0] omr;
        logic        rst_seen;
        logic [3:0]  attr_out;
        logic        stack_err;
        logic        core_wins;
        logic [2:0]  burst_len;
        logic        uf_counts;
        logic        bus_release_extra;
        logic        bus_enable;
        logic        grant_q;
        logic        busy_q;
        logic        ack_q;
        logic [17:0] stop_cnt;
        logic        stop_done;
    } omr_state_t;
endpackage

// ### hdl/omr_sync2.sv
`timescale 1ns/1ns
module omr_sync2 (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic d,
    output logic      q
);
    logic s1_r;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s1_r <= 1'b0;
            q    <= 1'b0;
        end else begin
            s1_r <= d;
            q    <= s1_r;
        end
    end
endmodule

// ### verification/cmr_bus_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// bus partner: arbiter grant, busy, acknowledge
// ----------------------------------------
module cmr_bus_model #(
    parameter int GAP = 2
) (
    input  wire logic clock,
    input  wire logic grant_req,
    input  wire logic ack_req,
    output logic      bus_grant_in,
    output logic      bus_busy_in,
    output logic      transfer_ack_in
);
    int gap_cnt;

    initial begin
        gap_cnt = 0;
        bus_grant_in = 1'b0;
        bus_busy_in = 1'b0;
        transfer_ack_in = 1'b0;
    end

    // every pin moves on the chip clock edge, both ways
    always @(posedge clock) begin
        transfer_ack_in <= ack_req;
        if (!grant_req) begin
            bus_grant_in <= 1'b0;
            bus_busy_in <= 1'b0;
            if (bus_grant_in)
                gap_cnt <= GAP;
        end else if (gap_cnt == 0) begin
            bus_grant_in <= 1'b1;
            bus_busy_in <= 1'b1;
        end
        if (gap_cnt > 0 && !bus_grant_in)
            gap_cnt <= gap_cnt - 1;
    end
endmodule

// ### verification/core_operating_mode_register_bench.sv
`timescale 1ns/1ns
module core_operating_mode_register_bench;
    logic                clock = 1'b0;
    logic                resetn = 1'b0;
    logic [3:0]          mode_pins = 4'h0;
    omr_pkg::omr_wr_t    wr = '0;
    omr_pkg::omr_stack_t stk = '0;
    logic [3:0]          attr_req = 4'h0;
    logic [1:0]          cpf = 2'h0;
    logic [1:0]          dpr = 2'h0;
    logic                g_req = 1'b0;
    logic                a_req = 1'b0;
    logic                stop_exit = 1'b0;
    logic                grant, busy, ack;
    logic [23:0]         reg_v, m, d;
    logic [3:0]          attr_o;
    logic [2:0]          blen;
    logic                s_err, c_win, ufc, rel, ben, g_acc, b_acc, a_acc, s_done;
    int                  n_errors = 0;
    int                  check_count = 0;
    int                  t0, t1;

    always #5 clock = ~clock;

    omr_core dut_u (.clock(clock), .resetn(resetn), .mode_pins(mode_pins), .wr(wr),
        .stk(stk), .attr_req(attr_req), .core_priority_field(cpf), .dma_priority(dpr),
        .bus_grant_in(grant), .bus_busy_in(busy), .transfer_ack_in(ack),
        .stop_exit(stop_exit), .operating_mode_control(reg_v),
        .address_attribute_out(attr_o), .stack_error(s_err), .core_wins(c_win),
        .burst_len(blen), .uf_counts(ufc), .bus_release_extra(rel), .bus_enable(ben),
        .grant_accepted(g_acc), .busy_accepted(b_acc), .ack_accepted(a_acc),
        .stop_done(s_done));

    cmr_bus_model bus_u (.clock(clock), .grant_req(g_req), .ack_req(a_req),
        .bus_grant_in(grant), .bus_busy_in(busy), .transfer_ack_in(ack));

    task chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one-hot by priority unless priority is disabled
    function automatic logic [3:0] exp_attr(input logic attr_priority_disable, input logic [3:0] r);
        return attr_priority_disable ? r : r[3] ? 4'h8 : r[2] ? 4'h4 : r[1] ? 4'h2 : {3'h0, r[0]};
    endfunction

    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task do_rst(input logic [3:0] p);
        resetn = 1'b0;
        mode_pins = p;
        cyc(16);
        resetn = 1'b1;
        cyc(1);
        m = 24'h000300 | {20'h0, p};
        chk(reg_v, m);
        chk({c_win, ben, blen}, 24'h19);
    endtask

    task wr_op(input logic [1:0] op, input logic [23:0] v);
        wr = '{1'b1, op, v};
        cyc(1);
        wr.wr_en = 1'b0;
        cyc(1);
        case (op)
            2'h0: m = v & 24'h1fffdf;
            2'h1: m = (m & 24'hff0000) | (m & v & 24'h00ffff);
            2'h2: m = m | (v & 24'h00ffdf);
            default: m = m;
        endcase
        chk(reg_v, m);
    endtask

    // stack event pulse; flags only move with the extension enabled
    task stk_ev(input logic pu, pl, wp, input logic [4:0] p, z);
        logic [23:0] o;
        o = m;
        stk = '{pu, pl, wp, p, z};
        cyc(1);
        if (m[20]) begin
            m[19] = m[19] | wp;
            m[18] = m[18] | (pu && p == z);
            m[17] = m[17] | (pl && p == 5'h0);
        end
        chk(reg_v, m);
        chk(s_err, (m[18] & ~o[18]) | (m[17] & ~o[17]));
        stk = '0;
        cyc(1);
        chk(s_err, 24'h0);
    endtask

    task lat(input logic k, output int t);
        t = 0;
        if (k) a_req = 1'b1;
        else g_req = 1'b1;
        while ((k ? a_acc : g_acc) !== 1'b1) begin
            t++;
            cyc(1);
            if (t > 20) begin
                n_errors++;
                test_done;
            end
        end
        chk(b_acc, g_acc);
        a_req = 1'b0;
        g_req = 1'b0;
        cyc(10);
        chk(k ? a_acc : g_acc, 24'h0);
    endtask

    initial begin
        void'($urandom(13));
        do_rst(4'($urandom));
        for (int i = 0; i < 24; i++) begin
            d = 24'($urandom);
            d[9:8] = i[1:0];
            cpf = 2'($urandom);
            dpr = 2'($urandom);
            attr_req = 4'($urandom);
            wr_op(2'($urandom), d);
            cyc(2);
            chk(blen, m[10] ? 24'h4 : 24'h1);
            chk({ufc, rel, ben}, {m[20], m[12], ~m[4]});
            if (m[9:8] != 2'h2)
                chk(c_win, m[9:8] == 2'h3 || (m[9:8] == 2'h0 && cpf >= dpr));
            chk(attr_o, exp_attr(m[14], attr_req));
        end
        wr_op(2'h0, 24'h000000);
        stk_ev(1'b1, 1'b0, 1'b0, 5'h3, 5'h3);
        wr_op(2'h0, 24'h100000);
        stk_ev(1'b1, 1'b0, 1'b0, 5'h3, 5'h4);
        stk_ev(1'b1, 1'b0, 1'b0, 5'h7, 5'h7);
        stk_ev(1'b1, 1'b0, 1'b0, 5'h7, 5'h7);
        stk_ev(1'b0, 1'b1, 1'b0, 5'h1, 5'h7);
        stk_ev(1'b0, 1'b1, 1'b0, 5'h0, 5'h7);
        stk_ev(1'b0, 1'b0, 1'b1, 5'h2, 5'h7);
        wr_op(2'h1, 24'h000000);
        wr_op(2'h2, 24'h00ffff);
        // move clearing the flag while a push at the limit sets it
        wr = '{1'b1, 2'h0, 24'h100000};
        stk = '{1'b1, 1'b0, 1'b0, 5'h3, 5'h3};
        cyc(1);
        wr.wr_en = 1'b0;
        stk = '0;
        cyc(1);
        m = 24'h140000;
        chk(reg_v, m);
        wr_op(2'h0, 24'h000000);
        lat(1'b0, t0);
        wr_op(2'h0, 24'h002000);
        lat(1'b0, t1);
        chk(t1 > t0, 24'h1);
        wr_op(2'h0, 24'h000000);
        lat(1'b1, t0);
        wr_op(2'h0, 24'h000800);
        lat(1'b1, t1);
        chk(t1 > t0, 24'h1);
        wr_op(2'h0, 24'h000040);
        stop_exit = 1'b1;
        cyc(1);
        stop_exit = 1'b0;
        t0 = 1;
        while (s_done !== 1'b1 && t0 < 40) begin
            t0++;
            cyc(1);
        end
        chk(t0 >= 15 && t0 <= 18, 24'h1);
        do_rst(4'($urandom));
        test_done;
    end
endmodule
